// ### tfr_pkg.sv
package tfr_pkg;
    // task file offsets, taken from the chip selects and the register address
    localparam logic [3:0] OFF_DATA = 4'h0;
    localparam logic [3:0] OFF_FAIL = 4'h1;
    localparam logic [3:0] OFF_LEN = 4'h2;
    localparam logic [3:0] OFF_BLK_LO = 4'h3;
    localparam logic [3:0] OFF_BLK_MID = 4'h4;
    localparam logic [3:0] OFF_BLK_HI = 4'h6;
    localparam logic [3:0] OFF_COND = 4'h7;
    localparam logic [3:0] OFF_DATA_EVEN = 4'h8;
    localparam logic [3:0] OFF_DATA_ODD = 4'h9;
    localparam logic [3:0] OFF_FAIL_DUP = 4'hd;
    localparam logic [3:0] OFF_SHADOW = 4'he;
    // device_condition bit positions
    localparam int ST_BUSY = 7;
    localparam int ST_ACCEPT = 6;
    localparam int ST_WFAULT = 5;
    localparam int ST_SETTLED = 4;
    localparam int ST_XFER = 3;
    localparam int ST_CORRECTED_DATA_FLAG = 2;
    localparam int ST_INDEX = 1;
    localparam int ST_ERR = 0;
    // failure_cause bit positions
    localparam int FC_BADBLK = 7;
    localparam int FC_UNREC = 6;
    localparam int FC_NOTFOUND = 4;
    localparam int FC_ABORT = 2;
    localparam int FC_GENERAL = 0;
    // host_control bit positions
    localparam int HC_SRST = 2;
    localparam int HC_IMASK = 1;
    // reset values and full length
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_LEN = 8'h01;
    localparam logic [8:0] FULL_LEN = 9'h100;
    // cycles the device stays busy after any reset before it accepts commands
    localparam int READY_NS = 1000;
    localparam int CLK_NS = 10;
    localparam int READY_CYC = (READY_NS + CLK_NS - 1) / CLK_NS;
endpackage : tfr_pkg

// ### tfr_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two flop synchroniser for pin inputs; first stage read only by second
module tfr_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] stage1;

    // reset constant only, never the pin
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stage1 <= INIT;
            dout <= INIT;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule : tfr_sync
`default_nettype wire

// ### tfr_task_file.sv
`timescale 1ns/1ps
`default_nettype none
module tfr_task_file #(
    parameter int READY_CYCLES = tfr_pkg::READY_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    // host pins, active low strobes and selects
    input wire logic task_sel_n,
    input wire logic ctrl_sel_n,
    input wire logic low_en_n,
    input wire logic high_en_n,
    input wire logic [2:0] reg_addr,
    input wire logic read_n,
    input wire logic write_n,
    input wire logic [15:0] host_data_in,
    output logic [15:0] host_data_out,
    output logic [15:0] host_data_oe,
    output logic host_irq,
    // device side: sector buffer
    output logic buf_wr,
    output logic buf_rd,
    output logic [15:0] buf_wdata,
    input wire logic [15:0] buf_rdata,
    // device side: command engine
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic [7:0] command_option,
    output logic [8:0] sectors_requested,
    output logic [23:0] start_address,
    output logic engine_reset,
    input wire logic eng_busy,
    input wire logic eng_xfer_req,
    input wire logic eng_done,
    input wire logic eng_fail,
    input wire logic eng_sector_done,
    input wire logic [7:0] eng_fail_cause,
    input wire logic [23:0] eng_fail_address,
    input wire logic eng_write_fault,
    input wire logic eng_corrected
);
    // synchronised pin inputs
    logic [7:0] pins_sync;
    logic [15:0] data_sync;
    logic task_sel, ctrl_sel, low_en, high_en, rd, wr;
    logic [2:0] addr;

    tfr_sync #(.W(8), .INIT(8'hfc)) u_sync_ctl (
        .clock(clock),
        .sys_rst(sys_rst),
        .din({task_sel_n, ctrl_sel_n, low_en_n, high_en_n, read_n,
              write_n, reg_addr[1:0]}),
        .dout(pins_sync)
    );
    tfr_sync #(.W(16), .INIT(16'h0000)) u_sync_dat (
        .clock(clock),
        .sys_rst(sys_rst),
        .din({host_data_in[15:1], reg_addr[2]} ^ 16'h0000),
        .dout(data_sync)
    );

    // reg_addr[2] rides in the data synchroniser's low bit, data bit 0
    // is resampled separately to keep the pin count of flops minimal
    logic data0_sync;
    tfr_sync #(.W(1), .INIT(1'b0)) u_sync_d0 (
        .clock(clock),
        .sys_rst(sys_rst),
        .din(host_data_in[0]),
        .dout(data0_sync)
    );

    assign task_sel = ~pins_sync[7];
    assign ctrl_sel = ~pins_sync[6];
    assign low_en = ~pins_sync[5];
    assign high_en = ~pins_sync[4];
    assign rd = ~pins_sync[3];
    assign wr = ~pins_sync[2];
    assign addr = {data_sync[0], pins_sync[1:0]};

    logic [15:0] wdata;
    assign wdata = {data_sync[15:1], data0_sync};

    // offset: second select maps onto upper half of the map
    logic [3:0] offset;
    assign offset = {ctrl_sel, addr};
    logic sel_any;
    assign sel_any = (task_sel ^ ctrl_sel) & (low_en | high_en);

    // strobe edges: act once per strobe, at its trailing edge for writes
    logic rd_q, wr_q;
    logic rd_start, wr_end;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
        end else begin
            rd_q <= rd & sel_any;
            wr_q <= wr & sel_any;
        end
    end
    assign rd_start = rd & sel_any & ~rd_q;
    assign wr_end = wr_q & ~wr;

    // latch address and lanes while write strobe is low
    logic [3:0] w_off;
    logic w_lo, w_hi;
    logic [15:0] w_data;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            w_off <= 4'h0;
            w_lo <= 1'b0;
            w_hi <= 1'b0;
            w_data <= 16'h0000;
        end else if (wr & sel_any) begin
            w_off <= offset;
            w_lo <= low_en;
            w_hi <= high_en;
            w_data <= wdata;
        end
    end

    // lane decode of one access: data port word, even byte, odd byte on low or high lane, or none
    typedef enum logic [3:0] {
        TFR_L_NONE = 4'h0,
        TFR_L_WORD = 4'h1,
        TFR_L_EVEN = 4'h2,
        TFR_L_ODD_LO = 4'h4,
        TFR_L_ODD_HI = 4'h8
    } tfr_lane_e;

    function automatic tfr_lane_e tfr_data_lane(input logic [3:0] off,
                                                input logic lo,
                                                input logic hi);
        tfr_lane_e l;
        l = TFR_L_NONE;
        if (lo && hi) begin
            // word on offsets 0, 8, 9 and also 1
            if (off == tfr_pkg::OFF_DATA || off == tfr_pkg::OFF_FAIL ||
                off == tfr_pkg::OFF_DATA_EVEN ||
                off == tfr_pkg::OFF_DATA_ODD) begin
                l = TFR_L_WORD;
            end
        end else if (lo) begin
            if (off == tfr_pkg::OFF_DATA || off == tfr_pkg::OFF_DATA_EVEN)
                l = TFR_L_EVEN;
            else if (off == tfr_pkg::OFF_DATA_ODD)
                l = TFR_L_ODD_LO;
        end else if (hi) begin
            if (off == tfr_pkg::OFF_DATA_EVEN ||
                off == tfr_pkg::OFF_DATA_ODD)
                l = TFR_L_ODD_HI;
        end
        return l;
    endfunction : tfr_data_lane

    // fail/option byte on high lane: offset 0 or 1 alone, or Dh as word
    function automatic logic tfr_fail_hi(input logic [3:0] off,
                                         input logic lo,
                                         input logic hi);
        return hi && ((!lo && off == tfr_pkg::OFF_FAIL) ||
                      (!lo && off == tfr_pkg::OFF_DATA) ||
                      (lo && off == tfr_pkg::OFF_FAIL_DUP));
    endfunction : tfr_fail_hi

    tfr_lane_e r_lane, w_lane;
    assign r_lane = tfr_data_lane(offset, low_en, high_en);
    assign w_lane = tfr_data_lane(w_off, w_lo, w_hi);

    // registers
    logic [7:0] failure_cause;
    logic [7:0] transfer_length;
    logic [7:0] start_block_low, start_block_mid, start_block_high;
    logic [7:0] host_control;
    logic [7:0] cmd_reg;
    logic cond_err, cond_corrected_data_flag, cond_wfault, accepts, irq_pending;
    logic [15:0] odd_hold;
    logic [$clog2(READY_CYCLES+1)-1:0] ready_cnt;

    logic soft_rst, dev_rst, busy;
    assign soft_rst = host_control[tfr_pkg::HC_SRST];
    assign dev_rst = sys_rst | soft_rst;
    assign engine_reset = dev_rst;
    assign busy = eng_busy | ~accepts | soft_rst;
    // host may touch command block only when not busy
    logic host_wr_ok;
    assign host_wr_ok = wr_end & ~busy;

    // host_control: writable even while busy
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            host_control <= tfr_pkg::RST_BYTE; // mask clear at reset
        end else if (wr_end && w_off == tfr_pkg::OFF_SHADOW && w_lo) begin
            host_control <= {5'h00, w_data[tfr_pkg::HC_SRST],
                             w_data[tfr_pkg::HC_IMASK], 1'b0};
        end
    end

    // ready counter: busy and not accepting until count runs out
    always_ff @(posedge clock) begin
        if (dev_rst) begin
            ready_cnt <= '0;
            accepts <= 1'b0;
        end else if (ready_cnt == ($bits(ready_cnt))'(READY_CYCLES)) begin
            accepts <= 1'b1;
        end else begin
            ready_cnt <= ready_cnt + 1'b1;
        end
    end

    // command block registers; engine reloads the address on fail
    always_ff @(posedge clock) begin
        if (dev_rst) begin
            transfer_length <= tfr_pkg::RST_LEN;
            start_block_low <= tfr_pkg::RST_LEN;
            start_block_mid <= tfr_pkg::RST_BYTE;
            start_block_high <= tfr_pkg::RST_BYTE;
            command_option <= tfr_pkg::RST_BYTE;
        end else if (eng_fail) begin
            start_block_low <= eng_fail_address[7:0];
            start_block_mid <= eng_fail_address[15:8];
            start_block_high <= eng_fail_address[23:16];
        end else if (eng_done) begin
            transfer_length <= tfr_pkg::RST_BYTE;
        end else if (eng_sector_done) begin
            transfer_length <= transfer_length - 8'h01;
        end else if (host_wr_ok) begin
            if (tfr_fail_hi(w_off, w_lo, w_hi))
                command_option <= w_data[15:8];
            else if (w_lo && !w_hi && (w_off == tfr_pkg::OFF_FAIL ||
                     w_off == tfr_pkg::OFF_FAIL_DUP))
                command_option <= w_data[7:0];
            if (w_lo) begin
                unique case (w_off)
                    tfr_pkg::OFF_LEN: transfer_length <= w_data[7:0];
                    tfr_pkg::OFF_BLK_LO: start_block_low <= w_data[7:0];
                    tfr_pkg::OFF_BLK_MID: start_block_mid <= w_data[7:0];
                    tfr_pkg::OFF_BLK_HI: start_block_high <= w_data[7:0];
                    default: ;
                endcase
            end
        end
    end

    // zero length requests a full 256 sectors
    assign sectors_requested = (transfer_length == 8'h00) ?
        tfr_pkg::FULL_LEN : {1'b0, transfer_length};
    assign start_address = {start_block_high, start_block_mid,
                            start_block_low};

    // command write at offset 7 starts the engine
    always_ff @(posedge clock) begin
        if (dev_rst) begin
            cmd_reg <= tfr_pkg::RST_BYTE;
            cmd_valid <= 1'b0;
        end else begin
            cmd_valid <= host_wr_ok && w_lo && w_off == tfr_pkg::OFF_COND;
            if (host_wr_ok && w_lo && w_off == tfr_pkg::OFF_COND)
                cmd_reg <= w_data[7:0];
        end
    end
    assign cmd_code = cmd_reg;

    // failure_cause and error flags; new command clears, fail sets
    always_ff @(posedge clock) begin
        if (dev_rst) begin
            failure_cause <= tfr_pkg::RST_BYTE;
            cond_err <= 1'b0;
            cond_wfault <= 1'b0;
            cond_corrected_data_flag <= 1'b0;
        end else begin
            if (eng_fail) begin
                // bits 5,3,1 forced zero abort from engine
                failure_cause <= eng_fail_cause & 8'hd5;
                cond_err <= 1'b1;
            end else if (cmd_valid) begin
                failure_cause <= tfr_pkg::RST_BYTE;
                cond_err <= 1'b0;
            end
            // faults set on the event, set wins over clear
            if (eng_write_fault)
                cond_wfault <= 1'b1;
            else if (cmd_valid)
                cond_wfault <= 1'b0;
            // corrected data noted, transfer keeps running
            if (eng_corrected)
                cond_corrected_data_flag <= 1'b1;
            else if (cmd_valid)
                cond_corrected_data_flag <= 1'b0;
        end
    end

    // interrupt pending on completion; status read at offset 7 clears it, offset Eh does not
    always_ff @(posedge clock) begin
        if (dev_rst) begin
            irq_pending <= 1'b0;
        end else if (eng_done | eng_fail) begin
            irq_pending <= 1'b1; // set wins over clear
        end else if (rd_start && offset == tfr_pkg::OFF_COND) begin
            irq_pending <= 1'b0;
        end
    end
    // active high request, gated by the mask bit
    assign host_irq = irq_pending & ~host_control[tfr_pkg::HC_IMASK];

    logic [7:0] status;
    always_comb begin
        status = 8'h00;
        status[tfr_pkg::ST_BUSY] = busy;
        status[tfr_pkg::ST_ACCEPT] = accepts;
        status[tfr_pkg::ST_WFAULT] = cond_wfault;
        status[tfr_pkg::ST_SETTLED] = accepts;
        status[tfr_pkg::ST_XFER] = eng_xfer_req & ~busy;
        status[tfr_pkg::ST_CORRECTED_DATA_FLAG] = cond_corrected_data_flag;
        status[tfr_pkg::ST_INDEX] = 1'b0;
        status[tfr_pkg::ST_ERR] = cond_err;
    end

    // buffer strobes: word moves once, bytes pair through odd_hold
    always_ff @(posedge clock) begin
        if (dev_rst) begin
            odd_hold <= 16'h0000;
        end else if (host_wr_ok && w_lane == TFR_L_EVEN) begin
            odd_hold[7:0] <= w_data[7:0];
        end else if (rd_start && r_lane == TFR_L_EVEN) begin
            odd_hold <= buf_rdata;
        end
    end
    // even byte pairs with odd byte; writes step the buffer on the odd half, reads on the even half
    assign buf_wr = host_wr_ok && (w_lane == TFR_L_WORD ||
                                   w_lane == TFR_L_ODD_LO ||
                                   w_lane == TFR_L_ODD_HI);
    always_comb begin
        buf_wdata = w_data;
        if (w_lane == TFR_L_ODD_LO)
            buf_wdata = {w_data[7:0], odd_hold[7:0]};
        else if (w_lane == TFR_L_ODD_HI)
            buf_wdata = {w_data[15:8], odd_hold[7:0]};
    end
    assign buf_rd = rd_start && !busy && (r_lane == TFR_L_WORD ||
                                          r_lane == TFR_L_EVEN);

    // read mux, held in flops while the read strobe is low
    logic [15:0] rdata;
    always_comb begin
        rdata = 16'h0000;
        unique case (r_lane)
            TFR_L_WORD: rdata = buf_rdata;
            TFR_L_EVEN: rdata = {8'h00, buf_rdata[7:0]};
            TFR_L_ODD_LO: rdata = {8'h00, odd_hold[15:8]};
            TFR_L_ODD_HI: rdata = {odd_hold[15:8], 8'h00};
            TFR_L_NONE: begin
                if (tfr_fail_hi(offset, low_en, high_en))
                    rdata = {failure_cause, 8'h00};
                else if (low_en) begin
                    unique case (offset)
                        tfr_pkg::OFF_FAIL, tfr_pkg::OFF_FAIL_DUP:
                            rdata[7:0] = failure_cause;
                        tfr_pkg::OFF_LEN: rdata[7:0] = transfer_length;
                        tfr_pkg::OFF_BLK_LO: rdata[7:0] = start_block_low;
                        tfr_pkg::OFF_BLK_MID: rdata[7:0] = start_block_mid;
                        tfr_pkg::OFF_BLK_HI: rdata[7:0] = start_block_high;
                        // both return status; only offset 7 clears
                        tfr_pkg::OFF_COND, tfr_pkg::OFF_SHADOW:
                            rdata[7:0] = busy ? 8'h80 : status;
                        default: rdata[7:0] = 8'h00;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            host_data_out <= 16'h0000;
            host_data_oe <= 16'h0000;
        end else if (rd_start) begin
            host_data_out <= rdata;
            host_data_oe <= {{8{high_en}}, {8{low_en}}};
        end else if (!(rd & sel_any)) begin
            host_data_oe <= 16'h0000;
        end
    end
endmodule : tfr_task_file
`default_nettype wire

// ### tfr_task_file_properties.sv
`timescale 1ns/1ps
`default_nettype none
// pin-level checks on the task file; sees only the top ports
module tfr_task_file_checker #(
    parameter int READY_CYCLES = tfr_pkg::READY_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic read_n,
    input wire logic [15:0] host_data_oe,
    input wire logic host_irq,
    input wire logic cmd_valid,
    input wire logic buf_wr,
    input wire logic engine_reset,
    input wire logic [8:0] sectors_requested
);
    property p_rst_eng;
        @(posedge clock) sys_rst |-> engine_reset;
    endproperty
    a_rst_eng: assert property (p_rst_eng)
        else $error("engine free during reset");
    property p_rst_out;
        @(posedge clock) sys_rst |=> host_data_oe == 16'h0000 && !host_irq;
    endproperty
    a_rst_out: assert property (p_rst_out)
        else $error("outputs live after reset");
    property p_cmd_pulse;
        @(posedge clock) disable iff (sys_rst) cmd_valid |=> !cmd_valid;
    endproperty
    a_cmd_pulse: assert property (p_cmd_pulse)
        else $error("command strobe too long");
    property p_wr_pulse;
        @(posedge clock) disable iff (sys_rst) buf_wr |=> !buf_wr;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse)
        else $error("buffer write too long");
    property p_lanes;
        @(posedge clock) disable iff (sys_rst)
            host_data_oe inside {16'h0000, 16'h00ff, 16'hff00, 16'hffff};
    endproperty
    a_lanes: assert property (p_lanes)
        else $error("partial lane drive");
    property p_len_range;
        @(posedge clock) disable iff (sys_rst)
            sectors_requested inside {[1:256]};
    endproperty
    a_len_range: assert property (p_len_range)
        else $error("sector request out of range");
    property p_oe_cause;
        @(posedge clock) disable iff (sys_rst)
            $rose(|host_data_oe) |-> $past(read_n, 2) == 1'b0;
    endproperty
    a_oe_cause: assert property (p_oe_cause)
        else $error("bus driven without read");
    property p_oe_drop;
        @(posedge clock) disable iff (sys_rst)
            $rose(read_n) |-> ##5 host_data_oe == 16'h0000;
    endproperty
    a_oe_drop: assert property (p_oe_drop)
        else $error("bus held after read");
endmodule : tfr_task_file_checker
bind tfr_task_file tfr_task_file_checker #(.READY_CYCLES(READY_CYCLES))
    chk_inst (.clock, .sys_rst, .read_n, .host_data_oe, .host_irq,
    .cmd_valid, .buf_wr, .engine_reset, .sectors_requested);
`default_nettype wire

// ### tfr_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// command engine and sector buffer standing behind the registers
module tfr_engine_model (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic engine_reset,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic buf_rd,
    output logic eng_busy,
    output logic eng_done,
    output logic eng_fail,
    output logic eng_sector_done,
    output logic eng_write_fault,
    output logic eng_corrected,
    output logic eng_xfer_req,
    output logic [7:0] eng_fail_cause,
    output logic [23:0] eng_fail_address,
    output logic [15:0] buf_rdata
);
    logic [5:0] left;
    logic [7:0] code;
    // odd codes run slow so the host can poke registers meanwhile
    always_ff @(posedge clock) begin
        eng_done <= 1'b0;
        eng_fail <= 1'b0;
        eng_sector_done <= 1'b0;
        eng_write_fault <= 1'b0;
        eng_corrected <= 1'b0;
        if (engine_reset) begin
            eng_busy <= 1'b0;
            eng_xfer_req <= 1'b0;
            left <= 6'h00;
        end else if (cmd_valid) begin
            eng_busy <= 1'b1;
            eng_xfer_req <= 1'b0;
            code <= cmd_code;
            left <= cmd_code[0] ? 6'h28 : 6'h03;
        end else if (eng_busy) begin
            left <= left - 6'h01;
            // last sector counted one cycle before the end
            eng_sector_done <= left == 6'h01;
            if (left == 6'h00) begin
                eng_busy <= 1'b0;
                eng_fail <= code == 8'hff;
                eng_done <= code != 8'hff;
                // failing code also faults the write; 21h corrects data
                eng_write_fault <= code == 8'hff;
                eng_corrected <= code == 8'h21;
                eng_xfer_req <= code == 8'h21;
            end
        end
    end
    // fault detail is junk outside the fail pulse, never a stale copy
    assign eng_fail_cause = eng_fail ? 8'h04 : 8'hfb;
    assign eng_fail_address = eng_fail ? 24'h00a5c3 : 24'hff5a3c;
    // buffer words step on each fetch
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            buf_rdata <= 16'hc3a5;
        end else if (buf_rd) begin
            buf_rdata <= buf_rdata + 16'h0101;
        end
    end
endmodule : tfr_engine_model
`default_nettype wire

// ### ata_task_file_registers_test.sv
`timescale 1ns/1ps
`default_nettype none
module ata_task_file_registers_test;
    logic clock = 1'b0;
    logic sys_rst, task_sel_n, ctrl_sel_n, low_en_n, high_en_n;
    logic read_n, write_n;
    logic eng_xfer_req, eng_sector_done, eng_write_fault, eng_corrected;
    logic [2:0] reg_addr;
    logic [15:0] host_data_in, host_data_out, host_data_oe, buf_wdata;
    logic [15:0] buf_rdata, prev_oe, last_wdata;
    logic host_irq, buf_wr, buf_rd, cmd_valid, engine_reset;
    logic eng_busy, eng_done, eng_fail;
    logic [7:0] cmd_code, command_option, eng_fail_cause, last_cmd;
    logic [8:0] sectors_requested;
    logic [23:0] start_address, eng_fail_address;
    logic [31:0] e;
    logic [31:0] exp_q[$];
    logic [2:0] offs[4] = '{3'h2, 3'h3, 3'h4, 3'h6};
    logic [7:0] rstv[4] = '{8'h01, 8'h01, 8'h00, 8'h00};
    logic [7:0] val[4];
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    tfr_task_file #(.READY_CYCLES(12)) tfr_task_file_inst (
        .clock, .sys_rst, .task_sel_n, .ctrl_sel_n, .low_en_n, .high_en_n,
        .reg_addr, .read_n, .write_n, .host_data_in, .host_data_out,
        .host_data_oe, .host_irq, .buf_wr, .buf_rd, .buf_wdata, .buf_rdata,
        .cmd_valid, .cmd_code, .command_option, .sectors_requested,
        .start_address, .engine_reset, .eng_busy, .eng_done, .eng_fail,
        .eng_fail_cause, .eng_fail_address, .eng_xfer_req,
        .eng_sector_done, .eng_write_fault, .eng_corrected
    );
    tfr_engine_model tfr_engine_model_inst (
        .clock, .sys_rst, .engine_reset, .cmd_valid, .cmd_code, .buf_rd,
        .eng_busy, .eng_done, .eng_fail, .eng_sector_done, .eng_write_fault,
        .eng_corrected, .eng_xfer_req, .eng_fail_cause, .eng_fail_address,
        .buf_rdata
    );
    always #5 clock = ~clock;
    task automatic test_done;
        if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    task automatic chk(input string what, input logic [31:0] x,
                       input logic [31:0] got);
        samples_checked++;
        if (x !== got) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, x, got);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick
    // one host cycle; ctl picks the second select, ln is {high_n, low_n}
    task automatic acc(input logic ctl, input logic [2:0] a,
                       input logic [1:0] ln, input logic wr,
                       input logic [15:0] d);
        @(posedge clock);
        task_sel_n <= ctl;
        ctrl_sel_n <= !ctl;
        reg_addr <= a;
        {high_en_n, low_en_n} <= ln;
        host_data_in <= wr ? d : ~d;
        if (wr) write_n <= 1'b0;
        else begin
            read_n <= 1'b0;
            exp_q.push_back({ln == 2'b00 ? 16'hffff :
                             ln[1] ? 16'h00ff : 16'hff00, d});
        end
        // strobe held long enough to cross the synchroniser
        tick(7);
        {read_n, write_n} <= 2'b11;
        host_data_in <= ~d;
        tick(1);
        {task_sel_n, ctrl_sel_n} <= 2'b11;
        tick(7);
    endtask : acc
    // read answers are paired with the oldest note in order
    always @(posedge clock) begin
        prev_oe <= host_data_oe;
        if (host_data_oe !== 16'h0000 && prev_oe === 16'h0000) begin
            if (exp_q.size() == 0) chk("stray read", 32'h0, 32'h1);
            else begin
                e = exp_q.pop_front();
                chk("read lanes", {16'h0, e[31:16]},
                    {16'h0, host_data_oe});
                chk("read data", {16'h0, e[31:16] & e[15:0]},
                    {16'h0, host_data_out & host_data_oe});
            end
        end
        if (buf_wr === 1'b1) last_wdata <= buf_wdata;
        if (cmd_valid === 1'b1) last_cmd <= cmd_code;
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            test_done();
        end
    end
    initial begin
        {task_sel_n, ctrl_sel_n, low_en_n, high_en_n} = 4'hf;
        {read_n, write_n, sys_rst} = 3'b111;
        reg_addr = 3'h0;
        host_data_in = 16'h0000;
        void'($urandom(32'h7a1102df));
        tick(20);
        sys_rst <= 1'b0;
        acc(1'b0, 3'h7, 2'b10, 1'b0, 16'h0080);
        tick(20);
        foreach (offs[i])
            acc(1'b0, offs[i], 2'b10, 1'b0, {8'h0, rstv[i]});
        acc(1'b0, 3'h7, 2'b10, 1'b0, 16'h0050);
        foreach (offs[i]) begin
            val[i] = 8'($urandom);
            acc(1'b0, offs[i], 2'b10, 1'b1, {8'h0, val[i]});
            acc(1'b0, offs[i], 2'b10, 1'b0, {8'h0, val[i]});
        end
        chk("address", {8'h0, val[3], val[2], val[1]},
            {8'h0, start_address});
        acc(1'b0, 3'h2, 2'b10, 1'b1, 16'h0000);
        chk("sectors", 32'h100, {23'h0, sectors_requested});
        acc(1'b0, 3'h1, 2'b10, 1'b1, 16'h005a);
        chk("option", 32'h5a, {24'h0, command_option});
        acc(1'b1, 3'h5, 2'b10, 1'b1, 16'h003c);
        chk("option", 32'h3c, {24'h0, command_option});
        acc(1'b0, 3'h0, 2'b01, 1'b1, 16'ha500);
        chk("option", 32'ha5, {24'h0, command_option});
        acc(1'b0, 3'h1, 2'b00, 1'b1, 16'h1234);
        chk("word write", 32'h1234, {16'h0, last_wdata});
        acc(1'b1, 3'h0, 2'b10, 1'b1, 16'h0078);
        acc(1'b1, 3'h1, 2'b10, 1'b1, 16'h0056);
        chk("byte pair", 32'h5678, {16'h0, last_wdata});
        acc(1'b1, 3'h0, 2'b00, 1'b0, 16'hc3a5);
        acc(1'b1, 3'h0, 2'b10, 1'b0, 16'h00a6);
        acc(1'b1, 3'h1, 2'b01, 1'b0, 16'hc400);
        acc(1'b1, 3'h6, 2'b10, 1'b1, 16'h0002);
        acc(1'b0, 3'h7, 2'b10, 1'b1, 16'h00ff);
        chk("command", 32'hff, {24'h0, last_cmd});
        // slow command: busy for about forty cycles before it fails
        tick(45);
        chk("masked irq", 32'h0, {31'h0, host_irq});
        acc(1'b1, 3'h6, 2'b10, 1'b1, 16'h0000);
        chk("irq", 32'h1, {31'h0, host_irq});
        acc(1'b1, 3'h6, 2'b10, 1'b0, 16'h0071);
        chk("irq kept", 32'h1, {31'h0, host_irq});
        acc(1'b0, 3'h7, 2'b10, 1'b0, 16'h0071);
        chk("irq cleared", 32'h0, {31'h0, host_irq});
        acc(1'b1, 3'h5, 2'b10, 1'b0, 16'h0004);
        acc(1'b0, 3'h1, 2'b01, 1'b0, 16'h0400);
        acc(1'b0, 3'h3, 2'b10, 1'b0, 16'h00c3);
        acc(1'b0, 3'h2, 2'b10, 1'b0, 16'h00ff);
        acc(1'b0, 3'h7, 2'b10, 1'b1, 16'h0021);
        // write while busy must be locked out
        acc(1'b0, 3'h3, 2'b10, 1'b1, 16'h0077);
        acc(1'b1, 3'h6, 2'b10, 1'b0, 16'h0080);
        tick(40);
        acc(1'b0, 3'h2, 2'b10, 1'b0, 16'h0000);
        acc(1'b0, 3'h3, 2'b10, 1'b0, 16'h00c3);
        acc(1'b0, 3'h7, 2'b10, 1'b0, 16'h005c);
        acc(1'b1, 3'h6, 2'b10, 1'b1, 16'h0004);
        chk("soft reset", 32'h1, {31'h0, engine_reset});
        acc(1'b0, 3'h7, 2'b10, 1'b0, 16'h0080);
        acc(1'b1, 3'h6, 2'b10, 1'b1, 16'h0000);
        chk("soft reset", 32'h0, {31'h0, engine_reset});
        tick(30);
        acc(1'b0, 3'h2, 2'b10, 1'b0, 16'h0001);
        acc(1'b0, 3'h7, 2'b10, 1'b0, 16'h0050);
        test_done();
    end
endmodule : ata_task_file_registers_test
`default_nettype wire
